/* hdl/rtca_top.sv */
// calendar clock control, alarm repeat and alarm date registers
// assumes a plain one-cycle register port, i_porn low at power-on,
// and the time counters and alarm compare living outside this block
//
// Summary of operation
// - value writes pass only when unlocked
// - ripple flag warns of rollover during reads
// - half-second bit high in second half
// - seconds write forces half-second to zero
// - clock output drives pin when enabled
// - on bit writable only when unlocked
// - unlock settable only with sequence enabled
// - control registers reset by power-on only
// - repeat count plus one alarms fire
// - count decrements, wraps only with repeat_wrap_enable
// - last alarm without repeat_wrap_enable clears enable
// - month as two BCD digits
// - day of month as two BCD digits
// - weekday digit, unused bits read zero
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module rtca_top import rtca_pkg::*; #(
	parameter longint SEC_CYCLES = SEC_CYC
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_porn,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_seq_en,
	input wire logic i_alarm_match,
	output logic [31:0] o_rdata,
	output logic o_irq,
	output logic o_clk_out,
	output logic o_clk_oe,
	output logic o_time_we,
	output logic [31:0] o_time_wdata,
	output logic o_alarm_event
);
	// true when a strobe addresses the given offset
	function automatic logic hit_at(input logic stb, input logic [7:0] adr,
		input logic [7:0] off);
		return stb && adr == off;
	endfunction

	rtca_if bus_if ();

	logic on_q;
	logic unlock_q;
	logic oe_q;
	logic [31:0] date_q;
	logic [IRQ_W-1:0] stat_q;
	logic [IRQ_W-1:0] mask_q;
	logic [31:0] rdata_q;
	logic irq_q;
	logic clk_out_q;
	logic clk_oe_q;
	logic time_we_q;
	logic [31:0] time_wdata_q;
	logic evt_out_q;
	logic [31:0] rd_d;
	logic [IRQ_W-1:0] evt_d;
	logic [IRQ_W-1:0] stat_d;
	logic wr_cc;
	logic wr_ac;
	logic wr_date;
	logic wr_time;
	logic wr_mask;
	logic rd_stat;
	logic alm_sync;

	// write decode
	assign wr_cc = hit_at(i_wr, i_addr, OFF_CLK_CTL);
	assign wr_ac = hit_at(i_wr, i_addr, OFF_ALM_CTL);
	assign wr_date = hit_at(i_wr, i_addr, OFF_ALM_DATE);
	assign wr_mask = hit_at(i_wr, i_addr, OFF_IRQ_MASK);
	assign wr_time = hit_at(i_wr, i_addr, OFF_TIME_VAL) && unlock_q;
	assign rd_stat = hit_at(i_rd, i_addr, OFF_IRQ_STAT);

	// alarm fields may move while a second rolls over
	assign alm_sync = on_q && bus_if.alm_en && bus_if.ripple;

	// shared signals toward the two sub-blocks
	assign bus_if.on = on_q;
	assign bus_if.sec_clr = wr_time;
	// alarm control load toward the repeat counter
	assign bus_if.alm_wr = wr_ac;
	assign bus_if.wdata = i_wdata;
	assign bus_if.alarm_in = i_alarm_match;

	rtca_half_second_flag #(
		.SEC_CYCLES(SEC_CYCLES)
	) u_half_second_flag (
		.i_clk(i_clk),
		.i_rstn(i_rstn),
		.s(bus_if.sec_mp)
	);

	rtca_repeat u_repeat (
		.i_clk(i_clk),
		.i_porn(i_porn),
		.a(bus_if.alm_mp)
	);

	// clock_control survives every reset but power-on
	always_ff @(posedge i_clk) begin
		if (!i_porn) begin
			on_q <= 1'b0;
			unlock_q <= 1'b0;
			oe_q <= 1'b0;
		end else if (wr_cc) begin
			if (unlock_q) begin
				on_q <= i_wdata[CC_ON];
			end
			if (!i_wdata[CC_UNLOCK] || i_seq_en) begin
				unlock_q <= i_wdata[CC_UNLOCK];
			end
			oe_q <= i_wdata[CC_OE];
		end
	end

	// alarm date compare value, unused bits never stored
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			date_q <= DATE_RST;
		end else if (wr_date) begin
			date_q <= i_wdata & DATE_MASK;
		end
	end

	// accepted value write handed to the time counters
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			time_we_q <= 1'b0;
			time_wdata_q <= 32'h0000_0000;
		end else begin
			time_we_q <= wr_time;
			if (wr_time) begin
				time_wdata_q <= i_wdata;
			end
		end
	end

	// interrupt events: alarm fired, second elapsed
	always_comb begin
		evt_d = '0;
		evt_d[IRQ_ALARM] = bus_if.event_p;
		evt_d[IRQ_SEC] = bus_if.sec_tick;
		// a read clears, a same-cycle event still lands
		stat_d = (rd_stat ? '0 : stat_q) | evt_d;
	end

	// sticky status and mask
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			stat_q <= IRQ_RST;
			mask_q <= IRQ_RST;
		end else begin
			stat_q <= stat_d;
			if (wr_mask) begin
				mask_q <= i_wdata[IRQ_W-1:0];
			end
		end
	end

	// level interrupt, registered so the pin is glitch free
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(stat_d & mask_q);
		end
	end

	// read mux; unmapped offsets read zero
	always_comb begin
		rd_d = 32'h0000_0000;
		case (i_addr)
			OFF_CLK_CTL: begin
				rd_d[CC_ON] = on_q;
				rd_d[CC_UNLOCK] = unlock_q;
				rd_d[CC_RIPPLE] = bus_if.ripple;
				rd_d[CC_HALF] = bus_if.half;
				rd_d[CC_OE] = oe_q;
			end
			OFF_ALM_CTL: begin
				rd_d[AC_EN] = bus_if.alm_en;
				rd_d[AC_WRAP] = bus_if.wrap;
				rd_d[AC_SYNC] = alm_sync;
				rd_d[CNT_W-1:0] = bus_if.cnt;
			end
			OFF_ALM_DATE: begin
				rd_d = date_q;
			end
			OFF_TIME_VAL: begin
				rd_d = time_wdata_q;
			end
			OFF_IRQ_STAT: begin
				rd_d[IRQ_W-1:0] = stat_q;
			end
			OFF_IRQ_MASK: begin
				rd_d[IRQ_W-1:0] = mask_q;
			end
			default: begin
				rd_d = 32'h0000_0000;
			end
		endcase
	end

	// data stand one cycle after the read strobe, zero otherwise
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			rdata_q <= 32'h0000_0000;
		end else begin
			// no wait states offered
			rdata_q <= i_rd ? rd_d : 32'h0000_0000;
		end
	end

	// second clock out to the pin, square wave from the half bit
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			clk_out_q <= 1'b0;
			clk_oe_q <= 1'b0;
		end else begin
			clk_oe_q <= on_q && oe_q;
			clk_out_q <= on_q && oe_q && bus_if.half;
		end
	end

	// alarm event mirrored to a pin for the wider chip
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			evt_out_q <= 1'b0;
		end else begin
			evt_out_q <= bus_if.event_p;
		end
	end

	assign o_rdata = rdata_q;
	assign o_irq = irq_q;
	assign o_clk_out = clk_out_q;
	assign o_clk_oe = clk_oe_q;
	assign o_time_we = time_we_q;
	assign o_time_wdata = time_wdata_q;
	assign o_alarm_event = evt_out_q;
endmodule // rtca_top

/* common/rtca_pkg.sv */
// constants for the calendar clock control and alarm repeat block
// assumes a 50 MHz register clock and a 32-bit word-aligned register port
package rtca_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CLK_CTL = 8'h00;
	localparam logic [7:0] OFF_ALM_CTL = 8'h04;
	localparam logic [7:0] OFF_ALM_DATE = 8'h08;
	localparam logic [7:0] OFF_TIME_VAL = 8'h0C;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
	// clock_control fields
	localparam int CC_ON = 15;
	localparam int CC_UNLOCK = 3;
	localparam int CC_RIPPLE = 2;
	localparam int CC_HALF = 1;
	localparam int CC_OE = 0;
	// alarm_control fields
	localparam int AC_EN = 15;
	localparam int AC_WRAP = 14;
	localparam int AC_SYNC = 12;
	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
	localparam logic [CNT_W-1:0] CNT_TOP = 8'hFF;
	// alarm_date_value fields
	localparam int MON_T_LSB = 20;
	localparam int MON_U_LSB = 16;
	localparam int DAY_T_LSB = 12;
	localparam int DAY_U_LSB = 8;
	localparam int WDAY_LSB = 0;
	localparam logic [31:0] DATE_MASK = 32'h00FF_FF0F;
	// seconds field of time_value_register
	localparam int SEC_LSB = 8;
	localparam int SEC_MSB = 14;
	// interrupt status and mask layout
	localparam int IRQ_W = 2;
	localparam int IRQ_ALARM = 0;
	localparam int IRQ_SEC = 1;
	// reset values
	localparam logic [31:0] DATE_RST = 32'h0000_0000;
	localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;
	// timing
	localparam longint CLK_HZ = 50_000_000;
	localparam longint SEC_TIME_MS = 1000;
	localparam longint SEC_CYC = (CLK_HZ * SEC_TIME_MS) / 1000;
	localparam int RIPPLE_CYC = 32;
endpackage

/* common/rtca_if.sv */
// signals shared by the control top, the second prescaler and the repeat counter
// assumes all three parts sit on one clock
`timescale 1ns/1ps
interface rtca_if;
	logic on;
	logic sec_clr;
	logic half;
	logic ripple;
	logic sec_tick;
	logic alm_wr;
	logic [31:0] wdata;
	logic alarm_in;
	logic alm_en;
	logic wrap;
	logic [7:0] cnt;
	logic event_p;
	modport top_mp(output on, sec_clr, alm_wr, wdata, alarm_in,
		input half, ripple, sec_tick, alm_en, wrap, cnt, event_p);
	modport sec_mp(input on, sec_clr, output half, ripple, sec_tick);
	modport alm_mp(input on, alm_wr, wdata, alarm_in,
		output alm_en, wrap, cnt, event_p);
endinterface

/* hdl/rtca_half_second_flag.sv */
// one-second prescaler giving the half-second and read-ripple status
// assumes on is a level from the control register
`timescale 1ns/1ps
module rtca_half_second_flag import rtca_pkg::*; #(
	parameter longint SEC_CYCLES = SEC_CYC
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	rtca_if.sec_mp s
);
	localparam int CW = $clog2(SEC_CYCLES);
	localparam logic [CW-1:0] LAST = CW'(SEC_CYCLES - 1);
	localparam logic [CW-1:0] HALF = CW'(SEC_CYCLES / 2);
	localparam logic [CW-1:0] RIP = CW'(SEC_CYCLES - RIPPLE_CYC);
	logic [CW-1:0] cnt_q;
	logic half_q;
	logic ripple_q;
	logic tick_q;

	// prescaler holds while the module is off
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			cnt_q <= '0;
		end else if (s.sec_clr) begin
			cnt_q <= '0;
		end else if (s.on) begin
			cnt_q <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
		end
	end

	// status follows the count one cycle later
	always_ff @(posedge i_clk) begin
		if (!i_rstn) begin
			half_q <= 1'b0;
			ripple_q <= 1'b0;
			tick_q <= 1'b0;
		end else begin
			half_q <= !s.sec_clr && cnt_q >= HALF;
			ripple_q <= s.on && !s.sec_clr && cnt_q >= RIP;
			tick_q <= s.on && !s.sec_clr && cnt_q == LAST;
		end
	end

	assign s.half = half_q;
	assign s.ripple = ripple_q;
	assign s.sec_tick = tick_q;
endmodule // rtca_half_second_flag

/* hdl/rtca_repeat.sv */
// alarm enable, wrap enable and repeat countdown
// assumes alarm_in is a one-cycle match pulse; reset only by power-on
`timescale 1ns/1ps
module rtca_repeat import rtca_pkg::*; (
	input wire logic i_clk,
	input wire logic i_porn,
	rtca_if.alm_mp a
);
	logic en_q;
	logic wrap_q;
	logic [CNT_W-1:0] cnt_q;
	logic evt_q;
	logic hit;

	// an event counts only while armed and running
	assign hit = a.alarm_in && a.on && en_q;

	// software load first, the alarm event overrides it
	always_ff @(posedge i_clk) begin
		if (!i_porn) begin
			en_q <= 1'b0;
			wrap_q <= 1'b0;
			cnt_q <= CNT_ZERO;
		end else begin
			if (a.alm_wr) begin
				en_q <= a.wdata[AC_EN];
				wrap_q <= a.wdata[AC_WRAP];
				cnt_q <= a.wdata[CNT_W-1:0];
			end
			if (hit) begin
				if (cnt_q != CNT_ZERO) begin
					cnt_q <= cnt_q - 1'b1;
				end else if (wrap_q) begin
					cnt_q <= CNT_TOP;
				end else begin
					en_q <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_porn) begin
			evt_q <= 1'b0;
		end else begin
			evt_q <= hit;
		end
	end

	assign a.alm_en = en_q;
	assign a.wrap = wrap_q;
	assign a.cnt = cnt_q;
	assign a.event_p = evt_q;
endmodule // rtca_repeat

/* verification/rtca_checker.sv */
// port assertions for the clock control and alarm repeat top
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/1ps
module rtca_checker import rtca_pkg::*; #(
	parameter longint SEC_CYCLES = SEC_CYC
) (
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_porn,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic i_seq_en,
	input wire logic i_alarm_match,
	input wire logic [31:0] o_rdata,
	input wire logic o_irq,
	input wire logic o_clk_out,
	input wire logic o_clk_oe,
	input wire logic o_time_we,
	input wire logic [31:0] o_time_wdata,
	input wire logic o_alarm_event
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_rstn);
	// decoded strobes, so that $past sees plain signals
	wire logic tw = i_wr && i_addr == OFF_TIME_VAL;
	wire logic cw = i_wr && i_addr == OFF_CLK_CTL;
	wire logic cr = i_rd && i_addr == OFF_CLK_CTL;
	wire logic dr = i_rd && i_addr == OFF_ALM_DATE;
	// accepted time write, then the clock pin low a cycle on
	sequence tw_clr_s;
		o_time_we ##1 !o_clk_out;
	endsequence
	time_we_a: assert property (o_time_we |-> $past(tw))
		else $error("time strobe without a time write");
	time_data_a: assert property (o_time_we |-> o_time_wdata == $past(i_wdata))
		else $error("time data differs from written word");
	ripple_half_a: assert property ($past(cr) && o_rdata[CC_RIPPLE] |-> o_rdata[CC_HALF])
		else $error("ripple seen in first half second");
	sec_clear_a: assert property (o_time_we |-> tw_clr_s)
		else $error("half second not cleared by time write");
	pin_gate_a: assert property (o_clk_out |-> o_clk_oe)
		else $error("clock out without enable");
	pin_hold_a: assert property ($changed(o_clk_oe) |-> $past(cw, 2))
		else $error("pin enable moved without a write");
	date_mask_a: assert property ($past(dr) |-> (o_rdata & ~DATE_MASK) == 32'h0)
		else $error("unused date bits read nonzero");
	evt_cause_a: assert property (o_alarm_event |-> $past(i_alarm_match, 2))
		else $error("alarm event without a match");
endmodule // rtca_checker

bind rtca_top rtca_checker #(.SEC_CYCLES(SEC_CYCLES)) i_rtca_checker (.i_clk, .i_rstn,
	.i_porn, .i_addr, .i_wdata, .i_wr, .i_rd, .i_seq_en, .i_alarm_match, .o_rdata, .o_irq,
	.o_clk_out, .o_clk_oe, .o_time_we, .o_time_wdata, .o_alarm_event);

/* verification/tb_rtca_top.sv */
// self-checking bench for the clock control and alarm repeat top
// assumes a shortened second of SC cycles so half seconds show quickly
`timescale 1ns/1ps
module tb_rtca_top import rtca_pkg::*; ;
	localparam longint SC = 200;
	logic i_clk, i_rstn, i_porn, i_wr, i_rd, i_seq_en, i_alarm_match, we;
	logic [7:0] i_addr;
	logic [31:0] i_wdata, o_rdata, o_time_wdata, d;
	logic o_irq, o_clk_out, o_clk_oe, o_time_we, o_alarm_event;
	int error_cnt = 0;
	int checks_done = 0;
	int n;
	rtca_top #(.SEC_CYCLES(SC)) i_rtca_top (.i_clk, .i_rstn, .i_porn, .i_addr, .i_wdata,
		.i_wr, .i_rd, .i_seq_en, .i_alarm_match, .o_rdata, .o_irq, .o_clk_out, .o_clk_oe,
		.o_time_we, .o_time_wdata, .o_alarm_event);
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e) begin
			error_cnt++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	// bus write; the time strobe is caught in the answer cycle
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= v;
		@(posedge i_clk);
		i_wr <= 1'b0;
		@(negedge i_clk);
		we = o_time_we;
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [7:0] a);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(negedge i_clk);
		d = o_rdata;
		@(posedge i_clk);
	endtask
	// one match pulse; the event pulse stands two cycles later
	task automatic alarm(input logic [31:0] ev);
		i_alarm_match <= 1'b1;
		@(posedge i_clk);
		i_alarm_match <= 1'b0;
		@(posedge i_clk);
		@(negedge i_clk);
		chk(o_alarm_event, ev);
		@(posedge i_clk);
	endtask
	task automatic t_lock();
		wr(OFF_TIME_VAL, 32'h0000_1200);
		chk(we, 1'b0);
		wr(OFF_CLK_CTL, 32'h0000_8009);
		rd(OFF_CLK_CTL);
		chk(d & 32'h8008, 32'h0);
		i_seq_en <= 1'b1;
		wr(OFF_CLK_CTL, 32'h0000_0008);
		wr(OFF_CLK_CTL, 32'h0000_8009);
		rd(OFF_CLK_CTL);
		chk(d & 32'h8009, 32'h8009);
		wr(OFF_TIME_VAL, 32'h0000_3400);
		chk(we, 1'b1);
		chk(o_time_wdata, 32'h0000_3400);
	endtask
	// count high cycles over one second, then hunt for the ripple window
	task automatic t_half();
		repeat (SC) @(posedge i_clk);
		n = 0;
		repeat (SC) begin
			@(negedge i_clk);
			n += o_clk_out;
		end
		chk(n, SC / 2);
		chk(o_clk_oe, 1'b1);
		@(posedge i_clk);
		n = 0;
		do begin
			rd(OFF_CLK_CTL);
			n++;
		end while (!d[CC_RIPPLE] && n < SC);
		chk(d[CC_RIPPLE], 1'b1);
		chk(d[CC_HALF], 1'b1);
		wr(OFF_TIME_VAL, 32'h0000_5900);
		rd(OFF_CLK_CTL);
		chk(d[CC_HALF], 1'b0);
		// on stays set, so no access follows a clear
		wr(OFF_CLK_CTL, 32'h0000_8008);
		@(negedge i_clk);
		chk(o_clk_oe, 1'b0);
		@(posedge i_clk);
	endtask
	// general reset alone leaves the control bits
	task automatic t_keep();
		i_rstn <= 1'b0;
		repeat (2) @(posedge i_clk);
		i_rstn <= 1'b1;
		@(posedge i_clk);
		rd(OFF_CLK_CTL);
		chk(d & 32'h8009, 32'h8008);
	endtask
	task automatic t_alarm();
		wr(OFF_IRQ_MASK, 32'h1);
		// count loaded while armed, sync bit masked from the check
		wr(OFF_ALM_CTL, 32'h0000_8002);
		for (int k = 2; k >= 0; k--) begin
			alarm(1);
			rd(OFF_ALM_CTL);
			chk(d & 32'hC0FF, (k > 0) ? 32'h8000 + k - 1 : 32'h0);
		end
		alarm(0);
		chk(o_irq, 1'b1);
		rd(OFF_IRQ_STAT);
		chk(d[IRQ_ALARM], 1'b1);
		@(negedge i_clk);
		chk(o_irq, 1'b0);
		@(posedge i_clk);
		wr(OFF_IRQ_MASK, 32'h0);
		wr(OFF_ALM_CTL, 32'h0000_C000);
		alarm(1);
		rd(OFF_ALM_CTL);
		chk(d & 32'hC0FF, 32'hC0FF);
		chk(o_irq, 1'b0);
	endtask
	task automatic t_date();
		wr(OFF_ALM_DATE, 32'hFF12_31F6);
		rd(OFF_ALM_DATE);
		chk(d, 32'h0012_3106);
		wr(OFF_ALM_DATE, 32'h0009_0900);
		rd(OFF_ALM_DATE);
		chk(d, 32'h0009_0900);
		rd(8'h3C);
		chk(d, 32'h0);
	endtask
	task automatic print_verdict();
		if (error_cnt == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	// power-on reset with the general reset, then the scenarios
	initial begin
		i_rstn = 1'b0;
		i_porn = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 8'h00;
		i_wdata = 32'h0;
		i_seq_en = 1'b0;
		i_alarm_match = 1'b0;
		repeat (20) @(posedge i_clk);
		i_rstn <= 1'b1;
		i_porn <= 1'b1;
		@(posedge i_clk);
		rd(OFF_ALM_CTL);
		chk(d & 32'hC0FF, 32'h0);
		t_lock();
		t_half();
		t_keep();
		t_alarm();
		t_date();
		print_verdict();
	end
	// watchdog well beyond the several hundred cycles the run needs
	initial begin
		repeat (20000) @(posedge i_clk);
		error_cnt++;
		print_verdict();
	end
endmodule // tb_rtca_top
